/* port_regs_cfg.svh */
// register offsets, field masks, reset values for the port register block
`ifndef PORT_REGS_CFG_SVH
`define PORT_REGS_CFG_SVH

// register address: bus_addr[7:4] = register kind, bus_addr[3:2] = 0, bus_addr[1:0] = port
`define OFF_LEVEL_IN    4'h0
`define OFF_OUT_VALUE   4'h1
`define OFF_LOGIC_OUT   4'h2
`define OFF_LOAD_BLOCK  4'h3
`define OFF_LOGIC_IN    4'h4
`define OFF_DRV_STATUS  4'h5
`define OFF_MODE_SEL    4'h6
`define OFF_DIRECTION   4'h7
`define OFF_DRIVE_TYPE  4'h8

`define KIND_LSB        4
`define PORT_SEL_LSB    0
`define PAD_LSB         2

`define PORT_A          2'h0
`define PORT_B          2'h1
`define PORT_C          2'h2
`define PORT_D          2'h3

`define PIN_W           8
`define NUM_PORTS       4
`define NUM_LOGIC_PORTS 3

`define CFG_RESET       8'h00
`define DATA_RESET      8'h00
`define RDATA_UNMAPPED  8'h00

`define ALL_PINS        8'hFF
`define NO_PINS         8'h00
`define PORT_D_PINS     8'h06
`define AB_OPEN_DRAIN   8'hF0
`define AB_SLEW         8'h0F
`define C_OPEN_DRAIN    8'hFF
`define C_SLEW          8'h00
`define D_OPEN_DRAIN    8'h00
`define D_SLEW          8'h06

`endif

/* port_regs_pkg.sv */
// types shared by the port register block
package port_regs_pkg;

  typedef struct packed {
    logic [7:0] mode_sel;
    logic [7:0] direction;
    logic [7:0] drive_type;
    logic [7:0] out_value;
    logic [7:0] load_block;
  } port_cfg_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] fast_slew;
  } pin_drive_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] kind;
    logic [1:0] port;
    logic       pad_ok;
    logic [7:0] wdata;
  } bus_req_t;

endpackage

/* pin_sync.sv */
// multi-bit two-flop synchroniser for pin levels
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 32,
  parameter int STAGES = 2
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  generate
    if (STAGES < 2) begin : g_bad_stages
      $error("pin_sync needs at least two stages");
    end
  endgenerate

  logic [STAGES-1:0][WIDTH-1:0] stage;
  logic [STAGES-1:0][WIDTH-1:0] next_stage;

  always_comb begin
    next_stage = {stage[STAGES-2:0], async_in};
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage <= '0;
    end else begin
      stage <= next_stage;
    end
  end

  assign sync_out = stage[STAGES-1];

endmodule // pin_sync

/* port_config_and_data_regs.sv */
// configuration and data registers of four general-purpose ports
`timescale 1ns/1ps
`include "port_regs_cfg.svh"

// Function
// - mode, direction, drive reset to zero
// - register bit n acts on pin n
// - mode 0 processor pin, 1 address bit
// - mode register only on ports A, B
// - direction 1 output, 0 input, default input
// - A-C output when direction or enable term
// - port D: two direction bits, no term
// - drive bit 1 open drain, 0 push-pull
// - slew drive bit 1 fast, 0 slow
// - drive bit roles per port fixed
// - pin-input register reads pin levels
// - output data stored, read, driven out
// - logic-out write loads unmasked cells only
// - mask bit 1 blocks load, default 0
// - logic-in cells readable on A-C
// - status shows effective output enables
// - logic-cell registers only on A-C
// - address out needs mode and direction/term
module port_config_and_data_regs
  import port_regs_pkg::*;
#(
  parameter int PIN_W = `PIN_W,
  parameter int SYNC_STAGES = 2
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic io_sel,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  output logic bus_rvalid,
  input wire logic [7:0] latched_addr,
  input wire logic [3:0][7:0] pin_in,
  output logic [3:0][7:0] pin_out,
  output logic [3:0][7:0] pin_oe,
  output logic [3:0][7:0] pin_fast_slew,
  input wire logic [2:0][7:0] logic_oe_term,
  input wire logic [2:0][7:0] output_logic_cell_q,
  input wire logic [2:0][7:0] input_logic_cell_q,
  output logic [2:0][7:0] output_logic_cell_load,
  output logic [7:0] output_logic_cell_data
);

  generate
    if (PIN_W != `PIN_W) begin : g_bad_width
      $error("port register block supports only 8-bit ports");
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // bus request decode

  bus_req_t req;

  always_comb begin
    req.wr = io_sel & bus_wr;
    req.rd = io_sel & bus_rd & ~bus_wr;
    req.kind = bus_addr[`KIND_LSB +: 4];
    req.port = bus_addr[`PORT_SEL_LSB +: 2];
    req.pad_ok = (bus_addr[`PAD_LSB +: 2] == 2'h0);
    req.wdata = bus_wdata;
  end

  // which bits of a register exist for a given port; zero means unmapped
  function automatic logic [7:0] impl_bits(input logic [3:0] kind, input logic [1:0] port);
    logic [7:0] pins;
    pins = (port == `PORT_D) ? `PORT_D_PINS : `ALL_PINS;
    unique case (kind)
      `OFF_LEVEL_IN, `OFF_OUT_VALUE: impl_bits = pins;
      `OFF_DIRECTION: impl_bits = pins;
      `OFF_DRIVE_TYPE: impl_bits = pins;
      `OFF_MODE_SEL: impl_bits = (port == `PORT_A || port == `PORT_B) ? `ALL_PINS : `NO_PINS;
      `OFF_LOGIC_OUT, `OFF_LOAD_BLOCK, `OFF_LOGIC_IN, `OFF_DRV_STATUS:
        impl_bits = (port == `PORT_D) ? `NO_PINS : `ALL_PINS;
      default: impl_bits = `NO_PINS;
    endcase
  endfunction

  // open-drain and slew capability per port
  function automatic logic [7:0] od_bits(input logic [1:0] port);
    unique case (port)
      `PORT_A, `PORT_B: od_bits = `AB_OPEN_DRAIN;
      `PORT_C: od_bits = `C_OPEN_DRAIN;
      default: od_bits = `D_OPEN_DRAIN;
    endcase
  endfunction

  function automatic logic [7:0] slew_bits(input logic [1:0] port);
    unique case (port)
      `PORT_A, `PORT_B: slew_bits = `AB_SLEW;
      `PORT_C: slew_bits = `C_SLEW;
      default: slew_bits = `D_SLEW;
    endcase
  endfunction

  logic [7:0] acc_bits;
  assign acc_bits = req.pad_ok ? impl_bits(req.kind, req.port) : `NO_PINS;

  //////////////////////////////////////////////////////////////////////////////
  // pin level synchroniser

  logic [3:0][7:0] pin_level;

  pin_sync #(
    .WIDTH(`NUM_PORTS * `PIN_W),
    .STAGES(SYNC_STAGES)
  ) u_pin_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in(pin_in),
    .sync_out(pin_level)
  );

  //////////////////////////////////////////////////////////////////////////////
  // configuration and data registers

  port_cfg_t [3:0] cfg;
  port_cfg_t [3:0] next_cfg;

  always_comb begin
    next_cfg = cfg;
    for (int p = 0; p < `NUM_PORTS; p++) begin
      if (req.wr && req.port == p[1:0] && acc_bits != `NO_PINS) begin
        unique case (req.kind)
          `OFF_MODE_SEL: next_cfg[p].mode_sel = req.wdata & acc_bits;
          `OFF_DIRECTION: next_cfg[p].direction = req.wdata & acc_bits;
          `OFF_DRIVE_TYPE: next_cfg[p].drive_type = req.wdata & acc_bits;
          `OFF_OUT_VALUE: next_cfg[p].out_value = req.wdata & acc_bits;
          `OFF_LOAD_BLOCK: next_cfg[p].load_block = req.wdata & acc_bits;
          default: next_cfg[p] = cfg[p];
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < `NUM_PORTS; p++) begin
        cfg[p].mode_sel <= `CFG_RESET;
        cfg[p].direction <= `CFG_RESET;
        cfg[p].drive_type <= `CFG_RESET;
        cfg[p].out_value <= `DATA_RESET;
        cfg[p].load_block <= `DATA_RESET;
      end
    end else begin
      cfg <= next_cfg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // output logic cell load strobes

  logic [2:0][7:0] cell_load;
  logic [2:0][7:0] next_cell_load;
  logic [7:0] cell_data;
  logic [7:0] next_cell_data;

  always_comb begin
    next_cell_data = cell_data;
    for (int p = 0; p < `NUM_LOGIC_PORTS; p++) begin
      next_cell_load[p] = `NO_PINS;
      if (req.wr && req.port == p[1:0] && req.kind == `OFF_LOGIC_OUT && req.pad_ok) begin
        next_cell_load[p] = ~cfg[p].load_block;
        next_cell_data = req.wdata;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cell_load <= '0;
      cell_data <= `DATA_RESET;
    end else begin
      cell_load <= next_cell_load;
      cell_data <= next_cell_data;
    end
  end

  assign output_logic_cell_load = cell_load;
  assign output_logic_cell_data = cell_data;

  //////////////////////////////////////////////////////////////////////////////
  // pin drivers, one slice per port

  logic [3:0][7:0] eff_oe;
  pin_drive_t [3:0] drive;
  pin_drive_t [3:0] next_drive;

  generate
    for (genvar gp = 0; gp < `NUM_PORTS; gp++) begin : g_port
      logic [7:0] term;
      logic [7:0] addr_mode;
      logic [7:0] value;
      logic [7:0] open_drain;

      if (gp < `NUM_LOGIC_PORTS) begin : g_term
        assign term = logic_oe_term[gp];
      end else begin : g_no_term
        assign term = `NO_PINS;
      end

      always_comb begin
        eff_oe[gp] = cfg[gp].direction | term;
        addr_mode = cfg[gp].mode_sel & eff_oe[gp];
        value = (addr_mode & latched_addr) | (~addr_mode & cfg[gp].out_value);
        open_drain = cfg[gp].drive_type & od_bits(2'(gp));
        next_drive[gp].out = value & ~open_drain;
        next_drive[gp].oe = eff_oe[gp] & ~(open_drain & value);
        next_drive[gp].fast_slew = cfg[gp].drive_type & slew_bits(2'(gp));
      end

      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          drive[gp] <= '0;
        end else begin
          drive[gp] <= next_drive[gp];
        end
      end

      assign pin_out[gp] = drive[gp].out;
      assign pin_oe[gp] = drive[gp].oe;
      assign pin_fast_slew[gp] = drive[gp].fast_slew;
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // read path

  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic rvalid;
  logic next_rvalid;

  always_comb begin
    logic [7:0] raw;
    logic [1:0] lp;
    raw = `RDATA_UNMAPPED;
    lp = (req.port == `PORT_D) ? `PORT_A : req.port;
    unique case (req.kind)
      `OFF_LEVEL_IN: raw = pin_level[req.port];
      `OFF_OUT_VALUE: raw = cfg[req.port].out_value;
      `OFF_MODE_SEL: raw = cfg[req.port].mode_sel;
      `OFF_DIRECTION: raw = cfg[req.port].direction;
      `OFF_DRIVE_TYPE: raw = cfg[req.port].drive_type;
      `OFF_LOAD_BLOCK: raw = cfg[req.port].load_block;
      `OFF_LOGIC_OUT: raw = output_logic_cell_q[lp];
      `OFF_LOGIC_IN: raw = input_logic_cell_q[lp];
      `OFF_DRV_STATUS: raw = eff_oe[lp];
      default: raw = `RDATA_UNMAPPED;
    endcase
    next_rdata = rdata;
    next_rvalid = req.rd;
    if (req.rd) begin
      next_rdata = raw & acc_bits;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= `RDATA_UNMAPPED;
      rvalid <= 1'b0;
    end else begin
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  assign bus_rdata = rdata;
  assign bus_rvalid = rvalid;

endmodule // port_config_and_data_regs

/* port_regs_props.sv */
// assertion checker for the port register block
`timescale 1ns/1ps
module port_regs_props (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic io_sel,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic [7:0] bus_rdata,
  input wire logic bus_rvalid,
  input wire logic [3:0][7:0] pin_oe,
  input wire logic [3:0][7:0] pin_fast_slew,
  input wire logic [2:0][7:0] input_logic_cell_q,
  input wire logic [2:0][7:0] output_logic_cell_load,
  input wire logic [7:0] output_logic_cell_data
);
  //////////////////////////////
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire rd_take = io_sel && bus_rd && !bus_wr;
  wire cell_wr = io_sel && bus_wr && bus_addr[7:4] == 4'h2 && bus_addr[3:2] == 2'h0;
  rd_answer_a: assert property (rd_take |=> bus_rvalid) else $error("read not answered");
  unmapped_zero_a: assert property (rd_take && bus_addr[7:4] > 4'h8 |=> bus_rdata == 8'h00)
    else $error("unmapped read not zero");
  ilc_read_a: assert property (rd_take && bus_addr == 8'h40 |=> bus_rdata == $past(input_logic_cell_q[0]))
    else $error("input cell read wrong");
  load_cause_a: assert property (|output_logic_cell_load |-> $past(cell_wr)) else $error("stray load");
  load_data_a: assert property (cell_wr && bus_addr[1:0] != 2'h3 |=> output_logic_cell_data == $past(bus_wdata))
    else $error("load data wrong");
  d_pins_a: assert property ((pin_oe[3] & 8'hF9) == 8'h00) else $error("port D extra enable");
  slew_roles_a: assert property (pin_fast_slew[2] == 8'h00 && (pin_fast_slew[3] & 8'hF9) == 8'h00
    && pin_fast_slew[0][7:4] == 4'h0 && pin_fast_slew[1][7:4] == 4'h0) else $error("slew on wrong pin");
  reset_clear_a: assert property ($rose(rst_n) |-> pin_oe == 32'h0 && !bus_rvalid) else $error("not cleared");
  cover property (rd_take);
  cover property (|output_logic_cell_load);
  cover property (io_sel && bus_wr);
endmodule // port_regs_props

bind port_config_and_data_regs port_regs_props port_regs_props_i (.sys_clk(sys_clk), .rst_n(rst_n),
  .io_sel(io_sel), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .pin_oe(pin_oe), .pin_fast_slew(pin_fast_slew),
  .input_logic_cell_q(input_logic_cell_q), .output_logic_cell_load(output_logic_cell_load),
  .output_logic_cell_data(output_logic_cell_data));

/* port_far_side.sv */
// far side model: pins with outside drivers, logic cells
`timescale 1ns/1ps
module port_far_side (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [3:0][7:0] pin_out,
  input wire logic [3:0][7:0] pin_oe,
  input wire logic [3:0][7:0] ext_level,
  input wire logic [2:0][7:0] cell_load,
  input wire logic [7:0] cell_data,
  output logic [3:0][7:0] pin_in,
  output logic [2:0][7:0] olc_q,
  output logic [2:0][7:0] ilc_q
);
  //////////////////////////////
  // released pins follow outside level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
  assign ilc_q = pin_in[2:0];
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      olc_q <= '0;
    end else begin
      olc_q <= (olc_q & ~cell_load) | ({3{cell_data}} & cell_load);
    end
  end
endmodule // port_far_side

/* port_config_and_data_regs_tb.sv */
// self-checking bench for the port register block
`timescale 1ns/1ps
module port_config_and_data_regs_tb;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic io_sel = 1'b0;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic bus_rvalid;
  logic [7:0] bus_addr = 8'h00;
  logic [7:0] bus_wdata = 8'h00;
  logic [7:0] latched_addr = 8'h96;
  logic [7:0] bus_rdata;
  logic [7:0] cell_data;
  logic [3:0][7:0] pin_in, pin_out, pin_oe, pin_fast_slew;
  logic [3:0][7:0] ext_level = 32'h5A5A5A3C;
  logic [2:0][7:0] oe_term = 24'h000000;
  logic [2:0][7:0] olc_q, ilc_q, cell_load;
  int n_mismatch = 0;
  int n_compared = 0;
  always #2 sys_clk = ~sys_clk;
  port_config_and_data_regs port_config_and_data_regs_i (.sys_clk(sys_clk), .rst_n(rst_n), .io_sel(io_sel),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .bus_rvalid(bus_rvalid), .latched_addr(latched_addr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_fast_slew(pin_fast_slew), .logic_oe_term(oe_term), .output_logic_cell_q(olc_q),
    .input_logic_cell_q(ilc_q), .output_logic_cell_load(cell_load), .output_logic_cell_data(cell_data));
  port_far_side port_far_side_i (.sys_clk(sys_clk), .rst_n(rst_n), .pin_out(pin_out), .pin_oe(pin_oe),
    .ext_level(ext_level), .cell_load(cell_load), .cell_data(cell_data), .pin_in(pin_in), .olc_q(olc_q),
    .ilc_q(ilc_q));
  //////////////////////////////
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [3:0] k, logic [1:0] p, logic [7:0] d);
    @(posedge sys_clk);
    io_sel <= 1'b1;
    bus_wr <= 1'b1;
    bus_addr <= {k, 2'b00, p};
    bus_wdata <= d;
    @(posedge sys_clk);
    io_sel <= 1'b0;
    bus_wr <= 1'b0;
  endtask
  task automatic rd(logic [3:0] k, logic [1:0] p, logic [7:0] e, string nm);
    @(posedge sys_clk);
    io_sel <= 1'b1;
    bus_rd <= 1'b1;
    bus_addr <= {k, 2'b00, p};
    @(posedge sys_clk);
    io_sel <= 1'b0;
    bus_rd <= 1'b0;
    #1;
    chk("rvalid", 8'h01, {7'h00, bus_rvalid});
    chk(nm, e, bus_rdata);
  endtask
  task automatic settle;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  task automatic complete_run;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  //////////////////////////////
  initial begin
    #20000;
    n_mismatch++;
    complete_run;
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      rd(4'h7, p[1:0], 8'h00, "direction");
      rd(4'h8, p[1:0], 8'h00, "drive");
      if (p < 2) rd(4'h6, p[1:0], 8'h00, "mode");
      if (p < 3) rd(4'h3, p[1:0], 8'h00, "mask");
    end
    $display("reset test done");
    wr(4'h7, 2'h0, 8'h07);
    wr(4'h1, 2'h0, 8'hA5);
    rd(4'h1, 2'h0, 8'hA5, "out value");
    settle;
    chk("oe A", 8'h07, pin_oe[0]);
    chk("out A", 8'hA5, pin_out[0]);
    rd(4'h0, 2'h0, 8'h3D, "level A");
    rd(4'h5, 2'h0, 8'h07, "status A");
    rd(4'h4, 2'h0, 8'h3D, "logic in A");
    $display("data test done");
    @(posedge sys_clk);
    oe_term <= 24'h00F000;
    wr(4'h7, 2'h1, 8'h03);
    wr(4'h7, 2'h3, 8'hFF);
    settle;
    chk("oe B", 8'hF3, pin_oe[1]);
    chk("oe D", 8'h06, pin_oe[3]);
    rd(4'h5, 2'h1, 8'hF3, "status B");
    rd(4'h7, 2'h3, 8'h06, "direction D");
    $display("enable test done");
    wr(4'h6, 2'h0, 8'hFF);
    wr(4'h7, 2'h0, 8'h0F);
    wr(4'h6, 2'h2, 8'hFF);
    rd(4'h6, 2'h2, 8'h00, "mode C");
    settle;
    chk("addr out A", 8'hA6, pin_out[0]);
    $display("mode test done");
    wr(4'h6, 2'h0, 8'h00);
    wr(4'h7, 2'h0, 8'hFF);
    wr(4'h8, 2'h0, 8'hFF);
    wr(4'h8, 2'h2, 8'hFF);
    wr(4'h8, 2'h3, 8'hFF);
    rd(4'h8, 2'h3, 8'h06, "drive D");
    settle;
    chk("out A od", 8'h05, pin_out[0]);
    chk("oe A od", 8'h5F, pin_oe[0]);
    chk("slew A", 8'h0F, pin_fast_slew[0]);
    chk("slew C", 8'h00, pin_fast_slew[2]);
    chk("slew D", 8'h06, pin_fast_slew[3]);
    rd(4'h5, 2'h0, 8'hFF, "status A od");
    $display("drive test done");
    wr(4'h3, 2'h0, 8'h0F);
    rd(4'h3, 2'h0, 8'h0F, "mask A");
    wr(4'h2, 2'h0, 8'h3C);
    rd(4'h2, 2'h0, 8'h30, "cells A");
    wr(4'h2, 2'h1, 8'h81);
    rd(4'h2, 2'h1, 8'h81, "cells B");
    rd(4'h2, 2'h3, 8'h00, "cells D");
    rd(4'h9, 2'h0, 8'h00, "unmapped");
    $display("cell test done");
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(4'h7, 2'h0, 8'h00, "direction after reset");
    rd(4'h8, 2'h0, 8'h00, "drive after reset");
    rd(4'h3, 2'h0, 8'h00, "mask after reset");
    $display("second reset test done");
    complete_run;
  end
endmodule // port_config_and_data_regs_tb
